// ### hdl/fskm_core.sv
// fsk modem digital core: mode control, phase-coherent modulator, receive outputs
`timescale 1ns/1ps
module fskm_core
   import fskm_pkg::*;
#(
   parameter int unsigned      BIT_CYCLES = BIT_CYC,
   parameter logic [DIV_W-1:0] DIV_OM     = 16'd180,
   parameter logic [DIV_W-1:0] DIV_OS     = 16'd213,
   parameter logic [DIV_W-1:0] DIV_AM     = 16'd102,
   parameter logic [DIV_W-1:0] DIV_AS     = 16'd113
) (
   input  wire logic             i_sys_clk,
   input  wire logic             i_srst,
   input  wire logic             i_originate_sel,
   input  wire logic             i_analog_loopback_select,
   input  wire logic             i_transmit_squelch,
   input  wire logic             i_carrier_above,
   input  wire logic [CD_W-1:0]  i_carrier_delay_timing,
   input  wire logic [E_W-1:0]   i_mark_energy,
   input  wire logic [E_W-1:0]   i_space_energy,
   input  wire logic             i_tx_valid,
   input  wire logic             i_tx_data,
   output logic                  o_tx_ready,
   output logic [DAC_W-1:0]      o_dac_level,
   output logic                  o_drive_en,
   output logic                  o_power_down,
   output logic                  o_rx_band_high,
   output logic                  o_loopback,
   output logic                  o_rx_data,
   output logic                  o_carrier_present_n
);
   fskm_state_s r;
   fskm_state_s next_r;
   logic        xtick;
   logic        reload;
   logic        bit_end;
   logic        q_valid;
   logic        q_data;
   logic        q_take;

   // divisor per tone: mark is data one, originate sends the low pair
   function automatic logic [DIV_W-1:0] div_of(input logic bitv, input logic orig);
      logic [DIV_W-1:0] d;
      d = orig ? (bitv ? DIV_OM : DIV_OS) : (bitv ? DIV_AM : DIV_AS);
      return d;
   endfunction

   // transmit bits queue here; a bit is taken once per bit period
   fskm_fifo #(
      .W (1),
      .D (FIFO_D)
   ) u_txq (
      .i_sys_clk   (i_sys_clk),
      .i_srst      (i_srst),
      .i_in_valid  (i_tx_valid),
      .i_in_data   (i_tx_data),
      .o_in_ready  (o_tx_ready),
      .o_out_valid (q_valid),
      .o_out_data  (q_data),
      .i_out_ready (q_take)
   );

   // chain: oscillator tick, then divider reload; the bit period counts system clocks on its own
   assign xtick   = (r.xcnt == XC_W'(XTAL_DIV - 1)) && (r.mode != FM_DOWN);
   assign reload  = xtick && (r.dcnt == '0);
   assign bit_end = (r.bcnt == BC_W'(BIT_CYCLES - 1)) && (r.mode != FM_DOWN);
   assign q_take  = bit_end;

   always_comb
   begin
      next_r    = r;
      next_r.s1 = '{originate: i_originate_sel, loopback: i_analog_loopback_select,
                    squelch: i_transmit_squelch, carrier: i_carrier_above};
      next_r.s2 = r.s1;
      // both pins high never happens in normal use, so it means sleep
      case ({r.s2.loopback, r.s2.squelch})
         2'b11:   next_r.mode = FM_DOWN;
         2'b01:   next_r.mode = FM_SQUELCH;
         default: next_r.mode = FM_RUN;
      endcase
      next_r.pdown     = next_r.mode == FM_DOWN;
      next_r.drive_en  = next_r.mode == FM_RUN;
      next_r.lpbk      = r.s2.loopback && (next_r.mode != FM_DOWN);
      // loop-back listens to its own transmit band
      next_r.band_high = r.s2.originate ^ r.s2.loopback;
      // oscillator-rate tick counter, frozen while powered down
      if (r.mode != FM_DOWN)
      begin
         next_r.xcnt = xtick ? '0 : r.xcnt + 1'b1;
      end
      // divisor is sampled only here, never mid-period
      if (reload)
      begin
         next_r.dcnt  = div_of(r.tx_bit, r.s2.originate) - 1'b1;
         next_r.phase = r.phase + 1'b1;
      end
      else if (xtick)
      begin
         next_r.dcnt = r.dcnt - 1'b1;
      end
      // bit period; an empty queue idles on mark
      if (r.mode != FM_DOWN)
      begin
         next_r.bcnt = bit_end ? '0 : r.bcnt + 1'b1;
      end
      if (bit_end)
      begin
         next_r.tx_bit = q_valid ? q_data : 1'b1;
      end
      next_r.dac = (r.mode == FM_DOWN) ? DAC_MID : fskm_sine(r.phase);
      // slow to qualify, quick to drop a marginal carrier
      if (!r.s2.carrier)
      begin
         next_r.cdcnt = '0;
         next_r.cd_n  = 1'b1;
      end
      else if (r.cdcnt >= i_carrier_delay_timing)
      begin
         next_r.cd_n = 1'b0;
      end
      else
      begin
         next_r.cdcnt = r.cdcnt + 1'b1;
      end
      next_r.rx_data = r.cd_n ? 1'b1 : (i_mark_energy >= i_space_energy);
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         r <= ST_RST;
      end
      else
      begin
         r <= next_r;
      end
   end

   // every output but o_tx_ready straight from the state register; o_tx_ready comes from the queue
   assign o_dac_level         = r.dac;
   assign o_drive_en          = r.drive_en;
   assign o_power_down        = r.pdown;
   assign o_rx_band_high      = r.band_high;
   assign o_loopback          = r.lpbk;
   assign o_rx_data           = r.rx_data;
   assign o_carrier_present_n = r.cd_n;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);

   sequence both_pins;
      r.s2.loopback && r.s2.squelch;
   endsequence

   // mode outputs follow the synced pins one edge later; a pulse of one cycle must show too
   a_power_down_entry: assert property (both_pins |=> o_power_down && !o_drive_en)
      else $error("power-down not entered");
   a_squelch_drive: assert property (r.s2.squelch |=> !o_drive_en)
      else $error("driver not silenced");
   a_band_select: assert property (##1 o_rx_band_high ==
      $past(r.s2.originate ^ r.s2.loopback))
      else $error("wrong receive band");
   a_tick_range: assert property (r.xcnt < XC_W'(XTAL_DIV))
      else $error("tick counter out of range");
   a_divisor_load: assert property (reload |=> r.dcnt == div_of($past(r.tx_bit),
      $past(r.s2.originate)) - 1'b1)
      else $error("wrong divisor loaded");
   a_mid_period: assert property (!reload && $past(r.dcnt) != '0 |-> ##0 1'b1 ##1
      (r.dcnt == $past(r.dcnt) || r.dcnt == $past(r.dcnt) - 1'b1))
      else $error("divider jumped mid-period");
   a_step_advance: assert property (reload |=> r.phase == $past(r.phase) + 1'b1)
      else $error("step counter did not advance");
   a_phase_keep: assert property (!reload |=> r.phase == $past(r.phase))
      else $error("step counter moved off reload");
   a_dac_table: assert property (r.mode != FM_DOWN |=>
      o_dac_level == fskm_sine($past(r.phase)))
      else $error("dac level not from table");
   a_carrier_qualify: assert property ($fell(o_carrier_present_n) |->
      $past(r.cdcnt) >= $past(i_carrier_delay_timing) && $past(r.s2.carrier))
      else $error("carrier qualified early");
   a_rx_clamp: assert property (r.cd_n |=> o_rx_data)
      else $error("receive data not clamped");
   a_rx_decide: assert property (!r.cd_n |=> o_rx_data ==
      ($past(i_mark_energy) >= $past(i_space_energy)))
      else $error("wrong mark or space decision");
endmodule

// ### hdl/fskm_fifo.sv
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module fskm_fifo #(
   parameter int unsigned W = 1,
   parameter int unsigned D = 4
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_srst,
   input  wire logic         i_in_valid,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_in_ready,
   output logic              o_out_valid,
   output logic [W-1:0]      o_out_data,
   input  wire logic         i_out_ready
);
   localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
      logic                rdy;
      logic                vld;
   } fskm_fifo_s;

   fskm_fifo_s r;
   fskm_fifo_s next_r;
   logic       push;
   logic       pop;

   // pointer wrap handles depths that are not a power of two
   always_comb
   begin
      next_r = r;
      push   = i_in_valid && r.rdy;
      pop    = r.vld && i_out_ready;
      if (push)
      begin
         next_r.mem[r.wp] = i_in_data;
         next_r.wp = (r.wp == AW'(D - 1)) ? '0 : r.wp + 1'b1;
      end
      if (pop)
      begin
         next_r.rp = (r.rp == AW'(D - 1)) ? '0 : r.rp + 1'b1;
      end
      next_r.cnt = r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
      next_r.rdy = next_r.cnt != (AW + 1)'(D);
      next_r.vld = next_r.cnt != '0;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         r     <= '0;
         r.rdy <= 1'b1;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign o_in_ready  = r.rdy;
   assign o_out_valid = r.vld;
   assign o_out_data  = r.mem[r.rp];
endmodule

// ### hdl/fskm_pkg.sv
// shared constants, types and the sine table of the fsk modem core
package fskm_pkg;
   localparam int unsigned CLK_HZ   = 200_000_000;
   localparam int unsigned XTAL_HZ  = 3_580_000;
   // longest tick period rounds down to whole cycles
   localparam int unsigned XTAL_DIV = CLK_HZ / XTAL_HZ;
   localparam int unsigned BAUD     = 300;
   localparam int unsigned BIT_CYC  = CLK_HZ / BAUD;
   localparam int unsigned STEP_W   = 4;
   localparam int unsigned DAC_W    = 8;
   localparam int unsigned DIV_W    = 16;
   localparam int unsigned CD_W     = 24;
   localparam int unsigned XC_W     = 8;
   localparam int unsigned BC_W     = 20;
   localparam int unsigned E_W      = 8;
   localparam int unsigned FIFO_D   = 4;
   localparam logic [DAC_W-1:0] DAC_MID = 8'h80;

   typedef enum logic [1:0] {FM_RUN, FM_SQUELCH, FM_DOWN} fskm_mode_e;

   // pins that cross into the clock domain
   typedef struct packed {
      logic originate;
      logic loopback;
      logic squelch;
      logic carrier;
   } fskm_pins_s;

   typedef struct packed {
      fskm_pins_s       s1;
      fskm_pins_s       s2;
      fskm_mode_e       mode;
      logic [XC_W-1:0]  xcnt;
      logic [DIV_W-1:0] dcnt;
      logic [STEP_W-1:0] phase;
      logic             tx_bit;
      logic [BC_W-1:0]  bcnt;
      logic [CD_W-1:0]  cdcnt;
      logic             cd_n;
      logic             rx_data;
      logic [DAC_W-1:0] dac;
      logic             drive_en;
      logic             pdown;
      logic             band_high;
      logic             lpbk;
   } fskm_state_s;

   localparam fskm_state_s ST_RST = '{mode: FM_RUN, tx_bit: 1'b1, cd_n: 1'b1,
                                      rx_data: 1'b1, dac: DAC_MID, default: '0};

   // sixteen-slot staircase sine, mid-scale centred
   function automatic logic [DAC_W-1:0] fskm_sine(input logic [STEP_W-1:0] s);
      logic [DAC_W-1:0] v;
      v = DAC_MID;
      case (s)
         4'h0: v = 8'h80;
         4'h1: v = 8'hb0;
         4'h2: v = 8'hda;
         4'h3: v = 8'hf6;
         4'h4: v = 8'hff;
         4'h5: v = 8'hf6;
         4'h6: v = 8'hda;
         4'h7: v = 8'hb0;
         4'h8: v = 8'h80;
         4'h9: v = 8'h50;
         4'ha: v = 8'h26;
         4'hb: v = 8'h0a;
         4'hc: v = 8'h01;
         4'hd: v = 8'h0a;
         4'he: v = 8'h26;
         default: v = 8'h50;
      endcase
      return v;
   endfunction
endpackage

// ### test/fskm_core_test.sv
// self-checking bench for the fsk modem core
`timescale 1ns/1ps
module fskm_core_test;
   import fskm_pkg::*;
   localparam int unsigned BC = 2000;
   localparam int unsigned TK = XTAL_DIV;
   localparam logic [15:0] DOM = 16'h0004;
   localparam logic [15:0] DOS = 16'h0006;
   localparam logic [15:0] DAM = 16'h0005;
   localparam logic [15:0] DAS = 16'h0007;
   logic             clk = 1'b0;
   logic             rst = 1'b1;
   logic             orig = 1'b1;
   logic             lb = 1'b0;
   logic             sq = 1'b0;
   logic             txv = 1'b0;
   logic             txd = 1'b1;
   logic             c_on = 1'b0;
   logic             m_tx = 1'b0;
   logic             tie = 1'b0;
   logic [CD_W-1:0]  dly = 24'h000014;
   logic             cab, rdy, den, pdn, bh, lpo, rxd, cdn;
   logic [E_W-1:0]   me, se;
   logic [DAC_W-1:0] dac;
   logic [DAC_W-1:0] prev = DAC_MID;
   logic             mon = 1'b0;
   logic             ichk = 1'b1;
   logic             iok = 1'b0;
   int               mismatches = 0;
   int               samples_checked = 0;
   int               ph = 0, last = 0, now = 0, n_mk = 0, n_sp = 0;
   logic [DAC_W-1:0] tbl [16] = '{8'h80, 8'hb0, 8'hda, 8'hf6, 8'hff, 8'hf6, 8'hda, 8'hb0,
                                  8'h80, 8'h50, 8'h26, 8'h0a, 8'h01, 8'h0a, 8'h26, 8'h50};

   initial
   begin
      forever #2.5 clk = ~clk;
   end

   fskm_core #(.BIT_CYCLES(BC), .DIV_OM(DOM), .DIV_OS(DOS), .DIV_AM(DAM), .DIV_AS(DAS)) u_dut (
      .i_sys_clk                (clk),
      .i_srst                   (rst),
      .i_originate_sel          (orig),
      .i_analog_loopback_select (lb),
      .i_transmit_squelch       (sq),
      .i_carrier_above          (cab),
      .i_carrier_delay_timing   (dly),
      .i_mark_energy            (me),
      .i_space_energy           (se),
      .i_tx_valid               (txv),
      .i_tx_data                (txd),
      .o_tx_ready               (rdy),
      .o_dac_level              (dac),
      .o_drive_en               (den),
      .o_power_down             (pdn),
      .o_rx_band_high           (bh),
      .o_loopback               (lpo),
      .o_rx_data                (rxd),
      .o_carrier_present_n      (cdn)
   );

   fskm_line_model u_line (
      .i_sys_clk       (clk),
      .i_carrier_on    (c_on),
      .i_mark_sent     (m_tx),
      .i_tie           (tie),
      .o_carrier_above (cab),
      .o_mark_energy   (me),
      .o_space_energy  (se)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // bounded wait; running out ends the run as a failure
   task automatic wait_sig(ref logic s, input logic v, input int lim);
      int n;
      n = 0;
      while (s !== v && n < lim)
      begin
         cyc(1);
         n++;
      end
      if (s !== v)
      begin
         mismatches++;
         test_done();
      end
   endtask

   // every staircase step is the next table slot; while ichk is set, steps are spaced by one legal divisor
   always @(negedge clk)
   begin
      now++;
      if (mon && dac !== prev)
      begin
         ph = (ph + 1) % 16;
         check(dac, tbl[ph]);
         if (ichk && iok)
         begin
            if (now - last == (orig ? DOM : DAM) * TK) n_mk++;
            else if (now - last == (orig ? DOS : DAS) * TK) n_sp++;
            else check(now - last, 32'h0);
         end
         last = now;
         prev = dac;
         iok = 1'b1;
      end
   end

   initial
   begin
      cyc(8);
      check({dac, den, pdn, lpo, rxd, cdn, rdy}, {DAC_MID, 6'b000111});
      rst = 1'b0;
      mon = 1'b1;
      cyc(8);
      check({den, pdn, bh}, 3'b101);
      $display("test reset done");
      // four space bits fill the queue; a fifth push is refused
      txd = 1'b0;
      wait_sig(rdy, 1'b1, 10);
      n_sp = 0;
      txv = 1'b1;
      cyc(4);
      check(rdy, 1'b0);
      cyc(1);
      txv = 1'b0;
      check(rdy, 1'b0);
      cyc(6 * BC);
      check(n_sp >= 22 && n_sp <= 26, 1'b1);
      check(n_mk > 0, 1'b1);
      check(rdy, 1'b1);
      $display("test originate tones done");
      // answer mode: interval check paused while the pin crosses over
      ichk = 1'b0;
      orig = 1'b0;
      cyc(600);
      check(bh, 1'b0);
      n_sp = 0;
      n_mk = 0;
      ichk = 1'b1;
      txv = 1'b1;
      cyc(1);
      txv = 1'b0;
      cyc(3 * BC);
      check(n_sp >= 4 && n_sp <= 6, 1'b1);
      check(n_mk > 0, 1'b1);
      $display("test answer tones done");
      // the interval in flight still carries the answer divisor, so pause its check
      ichk = 1'b0;
      orig = 1'b1;
      c_on = 1'b1;
      cyc(int'(dly));
      check(cdn, 1'b1);
      wait_sig(cdn, 1'b0, 8);
      cyc(3);
      check(rxd, 1'b0);
      m_tx = 1'b1;
      cyc(3);
      check(rxd, 1'b1);
      tie = 1'b1;
      m_tx = 1'b0;
      cyc(3);
      check(rxd, 1'b1);
      tie = 1'b0;
      cyc(3);
      check(rxd, 1'b0);
      c_on = 1'b0;
      cyc(4);
      check(cdn, 1'b1);
      repeat (30)
      begin
         cyc(1);
         check(rxd, 1'b1);
      end
      $display("test carrier done");
      // host walks every originate, loopback and squelch pin combination
      mon = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         {orig, lb, sq} = i[2:0];
         cyc(6);
         check({den, pdn, lpo}, {!sq, lb & sq, lb & !sq});
         if (lb & sq) check(dac, DAC_MID);
         else check(bh, orig ^ lb);
      end
      $display("test modes done");
      test_done();
   end
endmodule

// ### test/fskm_line_model.sv
// line-side stand-in: carrier comparator and detector energy words
`timescale 1ns/1ps
module fskm_line_model
   import fskm_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_carrier_on,
   input  wire logic        i_mark_sent,
   input  wire logic        i_tie,
   output logic             o_carrier_above = 1'b0,
   output logic [E_W-1:0]   o_mark_energy   = 8'h00,
   output logic [E_W-1:0]   o_space_energy  = 8'h00
);
   logic [E_W-1:0] noise = 8'h00;

   // without carrier the words wander, so a held receive output is really tested;
   // updates on the rising edge so the bench's falling-edge stimulus is never raced
   always @(posedge i_sys_clk)
   begin
      noise <= noise + 8'h25;
      o_carrier_above <= i_carrier_on;
      if (!i_carrier_on)
      begin
         o_mark_energy  <= noise;
         o_space_energy <= ~noise;
      end
      else
      begin
         o_mark_energy  <= i_tie ? 8'h70 : (i_mark_sent ? 8'hc0 : 8'h30);
         o_space_energy <= i_tie ? 8'h70 : (i_mark_sent ? 8'h30 : 8'hc0);
      end
   end
endmodule
